// [hw/sirqc_serial_irq_control.sv]
// Serial IRQ controller: mode, trigger-type and level-pending registers,
// reachable through a memory window and a configuration-space alias,
// plus the frame sequencer that drives and samples the shared IRQ line.
// Assumes an external pull-up on the line and same-clock reset requests.
// Summary of operation
// - Start frame lasts 4, 6 or 8 clocks per width code; code 11 reserved.
// - Quiet-select zero runs continuous polling; one runs quiet mode.
// - Recovery cycle drives line high, or releases it when float bit set.
// - Each of sixteen slots is edge-triggered at zero, level-triggered at one.
// - A signalled level slot sets the pending bit of the same number.
// - Edge-triggered slots never set a pending bit.
// - Writing one to a pending bit clears it until the next assertion.
// - Link, global or power-on reset clear all trigger-type bits.
// - Mode bits 7 to 4 read zero and ignore writes.
// - Memory-window and configuration registers are one storage, seen both ways.
`timescale 1ns/1ps
module sirqc_serial_irq_control (
    // Clock, reset, enable
    input  wire logic                        clk_sys,
    input  wire logic                        rst_n,
    input  wire logic                        ce,
    // Same-clock reset requests
    input  wire logic                        linkReset,
    input  wire logic                        globalReset,
    // Memory-window access
    input  wire logic                        memSel,
    input  wire logic                        memWr,
    input  wire logic [sirqc_pkg::REG_AW-1:0] memAddr,
    input  wire logic [1:0]                  memBe,
    input  wire logic [sirqc_pkg::REG_DW-1:0] memWdata,
    output logic      [sirqc_pkg::REG_DW-1:0] memRdata,
    output logic                             memRdValid,
    // Configuration-space access
    input  wire logic                        cfgSel,
    input  wire logic                        cfgWr,
    input  wire logic [sirqc_pkg::REG_AW-1:0] cfgAddr,
    input  wire logic [1:0]                  cfgBe,
    input  wire logic [sirqc_pkg::REG_DW-1:0] cfgWdata,
    output logic      [sirqc_pkg::REG_DW-1:0] cfgRdata,
    output logic                             cfgRdValid,
    // Serial IRQ line
    input  wire logic                        sirqIn,
    output logic                             sirqOut,
    output logic                             sirqOe,
    // Status
    output logic      [sirqc_pkg::SLOTS-1:0]  slotAsserted,
    output logic                             frameActive
);
    import sirqc_pkg::*;

    sirqc_reg_if memIf ();
    sirqc_reg_if cfgIf ();

    logic [7:0]       mode_r;
    logic [7:0]       mode_nxt;
    logic [15:0]      trig_r;
    logic [15:0]      trig_nxt;
    logic [15:0]      pend_r;
    logic [15:0]      pend_nxt;
    logic [15:0]      setVec;
    logic [15:0]      clrVec;
    sirqc_state_t     state_r;
    sirqc_state_t     state_nxt;
    logic [3:0]       cnt_r;
    logic [3:0]       cnt_nxt;
    logic [3:0]       slot_r;
    logic [3:0]       slot_nxt;
    logic [1:0]       phase_r;
    logic [1:0]       phase_nxt;
    logic [15:0]      seen_r;
    logic [15:0]      seen_nxt;
    logic             oe_r;
    logic             oe_nxt;
    logic             out_r;
    logic             out_nxt;
    logic             lineSync;
    logic             capture;
    logic             quietSelect;
    logic             recoveryFloatSelect;
    logic [1:0]       startWidth;
    logic [3:0]       startClks;

    // Access paths; both land on the same storage
    sirqc_regport #(
        .MODE_OFS (MEM_MODE_OFS),
        .TRIG_OFS (MEM_TRIG_OFS),
        .PEND_OFS (MEM_PEND_OFS)
    ) uMemPort (
        .clk_sys (clk_sys),
        .rst_n   (rst_n),
        .ce      (ce),
        .sel     (memSel),
        .wr      (memWr),
        .addr    (memAddr),
        .be      (memBe),
        .wdata   (memWdata),
        .rdata   (memRdata),
        .rdValid (memRdValid),
        .bus     (memIf.port)
    );

    sirqc_regport #(
        .MODE_OFS (CFG_MODE_OFS),
        .TRIG_OFS (CFG_TRIG_OFS),
        .PEND_OFS (CFG_PEND_OFS)
    ) uCfgPort (
        .clk_sys (clk_sys),
        .rst_n   (rst_n),
        .ce      (ce),
        .sel     (cfgSel),
        .wr      (cfgWr),
        .addr    (cfgAddr),
        .be      (cfgBe),
        .wdata   (cfgWdata),
        .rdata   (cfgRdata),
        .rdValid (cfgRdValid),
        .bus     (cfgIf.port)
    );

    // Line input from the pin
    sirqc_sync #(
        .W         (1),
        .RESET_VAL (1'h1)
    ) uLineSync (
        .clk_sys (clk_sys),
        .rst_n   (rst_n),
        .ce      (ce),
        .din     (sirqIn),
        .dout    (lineSync)
    );

    // Shared read values, identical for both paths
    assign memIf.modeVal = mode_r;
    assign memIf.trigVal = trig_r;
    assign memIf.pendVal = pend_r;
    assign cfgIf.modeVal = mode_r;
    assign cfgIf.trigVal = trig_r;
    assign cfgIf.pendVal = pend_r;

    assign quietSelect         = mode_r[MODE_QUIET_BIT];
    assign recoveryFloatSelect = mode_r[MODE_FLOAT_BIT];
    assign startWidth          = mode_r[MODE_WIDTH_LSB +: 2];
    assign startClks           = sirqc_start_clks(startWidth);

    // Slot sample seen two clocks late through the synchroniser
    assign capture = (state_r == ST_SLOT) && (phase_r == PH_TURN);
    always_comb begin
        setVec = 16'h0000;
        if (capture && !lineSync)
            setVec[slot_r] = trig_r[slot_r];
    end

    // Register next values; configuration writes land after window writes
    always_comb begin
        mode_nxt = mode_r;
        trig_nxt = trig_r;
        if (memIf.modeWe)
            mode_nxt = memIf.wdata[7:0] & MODE_WMASK;
        if (cfgIf.modeWe)
            mode_nxt = cfgIf.wdata[7:0] & MODE_WMASK;
        trig_nxt = (trig_nxt & ~sirqc_lane_mask(memIf.trigBe))
                 | (memIf.wdata & sirqc_lane_mask(memIf.trigBe));
        trig_nxt = (trig_nxt & ~sirqc_lane_mask(cfgIf.trigBe))
                 | (cfgIf.wdata & sirqc_lane_mask(cfgIf.trigBe));
        if (linkReset || globalReset)
            trig_nxt = TRIG_RESET;
        clrVec   = (memIf.wdata & sirqc_lane_mask(memIf.pendBe))
                 | (cfgIf.wdata & sirqc_lane_mask(cfgIf.pendBe));
        // A fresh assertion beats a clear in the same cycle
        pend_nxt = (pend_r & ~clrVec) | setVec;
    end

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            mode_r <= MODE_RESET;
            trig_r <= TRIG_RESET;
            pend_r <= PEND_RESET;
        end else if (ce) begin
            mode_r <= mode_nxt;
            trig_r <= trig_nxt;
            pend_r <= pend_nxt;
        end
    end

    // Frame sequencer
    always_comb begin
        state_nxt = state_r;
        cnt_nxt   = cnt_r;
        slot_nxt  = slot_r;
        phase_nxt = phase_r;
        seen_nxt  = seen_r;
        unique case (state_r)
            ST_IDLE: begin
                // Quiet mode waits for a peripheral to pull the line low
                if (!quietSelect || !lineSync) begin
                    state_nxt = ST_START;
                    cnt_nxt   = startClks - 4'h1;
                end
            end
            ST_START: begin
                if (cnt_r == 4'h0)
                    state_nxt = ST_START_REC;
                else
                    cnt_nxt = cnt_r - 4'h1;
            end
            ST_START_REC: state_nxt = ST_START_TA;
            ST_START_TA: begin
                state_nxt = ST_SLOT;
                slot_nxt  = 4'h0;
                phase_nxt = PH_SAMPLE;
            end
            ST_SLOT: begin
                if (phase_r != PH_TURN) begin
                    phase_nxt = phase_r + 2'h1;
                end else begin
                    seen_nxt[slot_r] = !lineSync;
                    phase_nxt        = PH_SAMPLE;
                    if (slot_r == 4'hF) begin
                        state_nxt = ST_STOP;
                        cnt_nxt   = (quietSelect ? STOP_CLKS_QUIET : STOP_CLKS_CONT) - 4'h1;
                    end else begin
                        slot_nxt = slot_r + 4'h1;
                    end
                end
            end
            ST_STOP: begin
                if (cnt_r == 4'h0)
                    state_nxt = ST_STOP_REC;
                else
                    cnt_nxt = cnt_r - 4'h1;
            end
            ST_STOP_REC: state_nxt = ST_STOP_TA;
            ST_STOP_TA: state_nxt = ST_IDLE;
        endcase
    end

    // Line drive follows the next state so the pins come from flops
    always_comb begin
        oe_nxt  = 1'h0;
        out_nxt = 1'h1;
        unique case (state_nxt)
            ST_START, ST_STOP: begin
                oe_nxt  = 1'h1;
                out_nxt = 1'h0;
            end
            ST_START_REC, ST_STOP_REC: oe_nxt = !recoveryFloatSelect;
            ST_IDLE, ST_START_TA, ST_SLOT, ST_STOP_TA: oe_nxt = 1'h0;
        endcase
    end

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            state_r <= ST_IDLE;
            cnt_r   <= 4'h0;
            slot_r  <= 4'h0;
            phase_r <= PH_SAMPLE;
            seen_r  <= 16'h0000;
            oe_r    <= 1'h0;
            out_r   <= 1'h1;
        end else if (ce) begin
            state_r <= state_nxt;
            cnt_r   <= cnt_nxt;
            slot_r  <= slot_nxt;
            phase_r <= phase_nxt;
            seen_r  <= seen_nxt;
            oe_r    <= oe_nxt;
            out_r   <= out_nxt;
        end
    end

    assign sirqOe       = oe_r;
    assign sirqOut      = out_r;
    assign slotAsserted = seen_r;
    assign frameActive  = (state_r != ST_IDLE);

    // Checks: helper counting consecutive driven-low clocks
    logic [3:0] lowLen_r;
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n)
            lowLen_r <= 4'h0;
        else if (ce)
            lowLen_r <= (oe_r && !out_r) ? lowLen_r + 4'h1 : 4'h0;
    end

    sequence s_slotCapture;
        ce && capture;
    endsequence

    property p_start_len;
        @(posedge clk_sys) disable iff (!rst_n)
        (state_r == ST_START_REC && lowLen_r != 4'h0) |-> lowLen_r == startClks;
    endproperty
    a_start_len: assert property (p_start_len) else $error("start frame length wrong");

    property p_stop_len;
        @(posedge clk_sys) disable iff (!rst_n)
        (state_r == ST_STOP_REC && lowLen_r != 4'h0)
            |-> lowLen_r == (quietSelect ? STOP_CLKS_QUIET : STOP_CLKS_CONT);
    endproperty
    a_stop_len: assert property (p_stop_len) else $error("stop frame length wrong");

    property p_cont_restart;
        @(posedge clk_sys) disable iff (!rst_n)
        (ce && state_r == ST_IDLE && !quietSelect) |=> state_r == ST_START ##1 (oe_r && !out_r);
    endproperty
    a_cont_restart: assert property (p_cont_restart) else $error("continuous mode did not restart");

    property p_rec_drive;
        @(posedge clk_sys) disable iff (!rst_n)
        (state_r == ST_START_REC || state_r == ST_STOP_REC)
            |-> (oe_r == !$past(recoveryFloatSelect)) && out_r;
    endproperty
    a_rec_drive: assert property (p_rec_drive) else $error("recovery drive wrong");

    property p_level_set;
        @(posedge clk_sys) disable iff (!rst_n)
        (s_slotCapture and (!lineSync && trig_r[slot_r])) |=> pend_r[$past(slot_r)];
    endproperty
    a_level_set: assert property (p_level_set) else $error("level slot not latched");

    property p_edge_never;
        @(posedge clk_sys) disable iff (!rst_n)
        ce |=> (pend_r & ~$past(pend_r) & ~$past(trig_r)) == 16'h0000;
    endproperty
    a_edge_never: assert property (p_edge_never) else $error("edge slot set pending");

    property p_rearm;
        @(posedge clk_sys) disable iff (!rst_n)
        (ce && clrVec != 16'h0000 && setVec == 16'h0000) |=> (pend_r & $past(clrVec)) == 16'h0000;
    endproperty
    a_rearm: assert property (p_rearm) else $error("pending bit not cleared");

    property p_trig_reset;
        @(posedge clk_sys) disable iff (!rst_n)
        (ce && (linkReset || globalReset)) |=> trig_r == TRIG_RESET;
    endproperty
    a_trig_reset: assert property (p_trig_reset) else $error("trigger bits survived reset");

    property p_unused_bits_zero;
        @(posedge clk_sys) disable iff (!rst_n)
        (memSel && !memWr && memAddr[7:1] == MEM_MODE_OFS[7:1]) |=> memRdata[15:4] == 12'h000;
    endproperty
    a_unused_bits_zero: assert property (p_unused_bits_zero) else $error("reserved mode bits nonzero");

    property p_alias;
        @(posedge clk_sys) disable iff (!rst_n)
        (ce && cfgIf.trigBe == 2'h3 && !linkReset && !globalReset) |=> trig_r == $past(cfgWdata);
    endproperty
    a_alias: assert property (p_alias) else $error("alias write not visible");

    property p_slot_order;
        @(posedge clk_sys) disable iff (!rst_n)
        (s_slotCapture and slot_r != 4'hF) |=> slot_r == $past(slot_r) + 4'h1 && phase_r == PH_SAMPLE;
    endproperty
    a_slot_order: assert property (p_slot_order) else $error("slot order broken");
endmodule

// [hw/sirqc_pkg.sv]
// Shared constants, types and helpers of the serial IRQ control block.
// Assumes a single 100 MHz clock that also paces the serial IRQ stream.
package sirqc_pkg;
    // Register access widths
    localparam int REG_AW = 8;
    localparam int REG_DW = 16;
    localparam int SLOTS  = 16;

    // Memory-window and configuration-space offsets
    localparam logic [7:0] MEM_MODE_OFS = 8'h48;
    localparam logic [7:0] MEM_TRIG_OFS = 8'h4A;
    localparam logic [7:0] MEM_PEND_OFS = 8'h4C;
    localparam logic [7:0] CFG_MODE_OFS = 8'hE0;
    localparam logic [7:0] CFG_TRIG_OFS = 8'hE2;
    localparam logic [7:0] CFG_PEND_OFS = 8'hE4;

    // Reset values and writable bits
    localparam logic [7:0]  MODE_RESET = 8'h00;
    localparam logic [7:0]  MODE_WMASK = 8'h0F;
    localparam logic [15:0] TRIG_RESET = 16'h0000;
    localparam logic [15:0] PEND_RESET = 16'h0000;

    // Mode register fields
    localparam int MODE_FLOAT_BIT = 0;
    localparam int MODE_QUIET_BIT = 1;
    localparam int MODE_WIDTH_LSB = 2;
    localparam logic [1:0] WIDTH_4 = 2'h0;
    localparam logic [1:0] WIDTH_6 = 2'h1;
    localparam logic [1:0] WIDTH_8 = 2'h2;

    // Frame timing, in stream clocks
    localparam logic [3:0] START_CLKS_4    = 4'h4;
    localparam logic [3:0] START_CLKS_6    = 4'h6;
    localparam logic [3:0] START_CLKS_8    = 4'h8;
    localparam logic [3:0] STOP_CLKS_QUIET = 4'h2;
    localparam logic [3:0] STOP_CLKS_CONT  = 4'h3;

    // Phases inside one interrupt slot
    localparam logic [1:0] PH_SAMPLE  = 2'h0;
    localparam logic [1:0] PH_RECOVER = 2'h1;
    localparam logic [1:0] PH_TURN    = 2'h2;

    typedef enum logic [2:0] {
        ST_IDLE, ST_START, ST_START_REC, ST_START_TA,
        ST_SLOT, ST_STOP, ST_STOP_REC, ST_STOP_TA
    } sirqc_state_t;

    // Start frame length; the reserved code falls back to the shortest width
    function automatic logic [3:0] sirqc_start_clks(input logic [1:0] w);
        case (w)
            WIDTH_6: sirqc_start_clks = START_CLKS_6;
            WIDTH_8: sirqc_start_clks = START_CLKS_8;
            default: sirqc_start_clks = START_CLKS_4;
        endcase
    endfunction

    // Byte enables widened to a 16-bit mask
    function automatic logic [15:0] sirqc_lane_mask(input logic [1:0] be);
        sirqc_lane_mask = {{8{be[1]}}, {8{be[0]}}};
    endfunction
endpackage

// [hw/sirqc_reg_if.sv]
// Decoded register strobes between an access port and the register core.
// Assumes both ends run on clk_sys.
`timescale 1ns/1ps
interface sirqc_reg_if;
    logic        modeWe;
    logic [1:0]  trigBe;
    logic [1:0]  pendBe;
    logic [15:0] wdata;
    logic [7:0]  modeVal;
    logic [15:0] trigVal;
    logic [15:0] pendVal;

    modport port (output modeWe, trigBe, pendBe, wdata, input modeVal, trigVal, pendVal);
    modport core (input modeWe, trigBe, pendBe, wdata, output modeVal, trigVal, pendVal);
endinterface

// [hw/sirqc_sync.sv]
// Two-stage synchroniser for inputs arriving from a pin.
// Assumes the first stage is read by the second stage only.
`timescale 1ns/1ps
module sirqc_sync #(
    parameter int         W         = 1,
    parameter logic [0:0] RESET_VAL = 1'h1
) (
    // Clock and reset
    input  wire logic         clk_sys,
    input  wire logic         rst_n,
    input  wire logic         ce,
    // Data
    input  wire logic [W-1:0] din,
    output logic      [W-1:0] dout
);
    logic [W-1:0] meta_r;
    logic [W-1:0] sync_r;

    // Both stages freeze with the clock enable
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            meta_r <= {W{RESET_VAL}};
            sync_r <= {W{RESET_VAL}};
        end else if (ce) begin
            meta_r <= din;
            sync_r <= meta_r;
        end
    end

    assign dout = sync_r;
endmodule

// [hw/sirqc_regport.sv]
// One register access path: decode, write strobes, registered read data.
// Assumes the core applies the strobes in the same cycle.
`timescale 1ns/1ps
module sirqc_regport
    import sirqc_pkg::*;
#(
    parameter logic [7:0] MODE_OFS = MEM_MODE_OFS,
    parameter logic [7:0] TRIG_OFS = MEM_TRIG_OFS,
    parameter logic [7:0] PEND_OFS = MEM_PEND_OFS
) (
    // Clock and reset
    input  wire logic              clk_sys,
    input  wire logic              rst_n,
    input  wire logic              ce,
    // Access request
    input  wire logic              sel,
    input  wire logic              wr,
    input  wire logic [REG_AW-1:0] addr,
    input  wire logic [1:0]        be,
    input  wire logic [REG_DW-1:0] wdata,
    // Read answer
    output logic      [REG_DW-1:0] rdata,
    output logic                   rdValid,
    // Core side
    sirqc_reg_if.port              bus
);
    logic              hitMode;
    logic              hitTrig;
    logic              hitPend;
    logic [REG_DW-1:0] rdata_r;
    logic [REG_DW-1:0] rdata_nxt;
    logic              rdValid_r;
    logic              rdValid_nxt;

    // Halfword decode; address bit 0 is ignored
    assign hitMode = sel && (addr[7:1] == MODE_OFS[7:1]);
    assign hitTrig = sel && (addr[7:1] == TRIG_OFS[7:1]);
    assign hitPend = sel && (addr[7:1] == PEND_OFS[7:1]);

    // Write strobes; unmapped writes fall away
    assign bus.modeWe = wr && hitMode && be[0];
    assign bus.trigBe = (wr && hitTrig) ? be : 2'h0;
    assign bus.pendBe = (wr && hitPend) ? be : 2'h0;
    assign bus.wdata  = wdata;

    // Read mux; unmapped reads answer zero
    always_comb begin
        rdValid_nxt = sel && !wr;
        rdata_nxt   = rdata_r;
        if (sel && !wr) begin
            if (hitMode)
                rdata_nxt = {8'h00, bus.modeVal};
            else if (hitTrig)
                rdata_nxt = bus.trigVal;
            else if (hitPend)
                rdata_nxt = bus.pendVal;
            else
                rdata_nxt = 16'h0000;
        end
    end

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            rdata_r   <= 16'h0000;
            rdValid_r <= 1'h0;
        end else if (ce) begin
            rdata_r   <= rdata_nxt;
            rdValid_r <= rdValid_nxt;
        end
    end

    assign rdata   = rdata_r;
    assign rdValid = rdValid_r;
endmodule

// [test/sirqc_periph.sv]
// Peripheral model on the shared serial IRQ line: answers in chosen slots.
// Assumes a pulled-up line and the host's start frame of at least 4 clocks.
`timescale 1ns/1ps
module sirqc_periph (
    // Clock and reset
    input  wire logic        clk_sys,
    input  wire logic        rst_n,
    // Line and requests
    input  wire logic        line,
    input  wire logic        wake,
    input  wire logic [15:0] slotMask,
    output logic             pullLow
);
    logic [3:0] lowCnt;
    logic [5:0] t;
    logic [5:0] k;
    logic       slotLow;

    assign k = t - 6'h1;
    // Wake pull only while t is zero, so it never overlaps a slot answer
    assign pullLow = slotLow | (wake & (t == 6'h0));

    // Start seen as a long low run; then 16 slots of 3 clocks, low in sample
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            lowCnt  <= 4'h0;
            t       <= 6'h0;
            slotLow <= 1'b0;
        end else begin
            lowCnt <= line ? 4'h0 : ((lowCnt == 4'hF) ? lowCnt : lowCnt + 4'h1);
            if (t != 6'h0) begin
                t       <= (t == 6'h30) ? 6'h0 : t + 6'h1;
                slotLow <= ((k % 6'h3) == 6'h0) && slotMask[k / 6'h3];
            end else begin
                slotLow <= 1'b0;
                if (line && lowCnt >= 4'h4) begin
                    t <= 6'h1;
                end
            end
        end
    end
endmodule

// [test/sirqc_serial_irq_control_bench.sv]
// Bench for the serial IRQ control block: register tasks and frame checks.
// Assumes the peripheral model sirqc_periph and a pulled-up IRQ line.
`timescale 1ns/1ps
module sirqc_serial_irq_control_bench;
    import sirqc_pkg::*;
    logic        clk_sys = 1'b0;
    logic        rst_n = 1'b0;
    logic        linkReset = 1'b0;
    logic        globalReset = 1'b0;
    logic        wake = 1'b0;
    logic        memSel = 1'b0;
    logic        memWr = 1'b0;
    logic        cfgSel = 1'b0;
    logic        cfgWr = 1'b0;
    logic [7:0]  memAddr = 8'h00;
    logic [7:0]  cfgAddr = 8'h00;
    logic [1:0]  memBe = 2'h0;
    logic [1:0]  cfgBe = 2'h0;
    logic [15:0] memWdata = 16'h0000;
    logic [15:0] cfgWdata = 16'h0000;
    logic [15:0] mask = 16'h0000;
    logic [15:0] memRdata, cfgRdata, slotAsserted;
    logic        memRdValid, cfgRdValid, sirqOut, sirqOe, frameActive, pullLow, line;
    logic [7:0]  ofs [6] = '{MEM_MODE_OFS, MEM_TRIG_OFS, MEM_PEND_OFS, CFG_MODE_OFS, CFG_TRIG_OFS, CFG_PEND_OFS};
    int          error_cnt = 0;
    int          n_compared = 0;

    always #5 clk_sys = ~clk_sys;
    // Pull-up wins when nobody drives the line
    assign line = sirqOe ? sirqOut : ~pullLow;

    sirqc_serial_irq_control dut (.clk_sys, .rst_n, .ce(1'b1), .linkReset, .globalReset,
        .memSel, .memWr, .memAddr, .memBe, .memWdata, .memRdata, .memRdValid,
        .cfgSel, .cfgWr, .cfgAddr, .cfgBe, .cfgWdata, .cfgRdata, .cfgRdValid,
        .sirqIn(line), .sirqOut, .sirqOe, .slotAsserted, .frameActive);
    sirqc_periph periph (.clk_sys, .rst_n, .line, .wake, .slotMask(mask), .pullLow);

    task automatic chk(input string n, input logic [15:0] e, input logic [15:0] g);
        n_compared++;
        if (g !== e) begin
            $display("[ERR] %s expected %h seen %h", n, e, g);
            error_cnt++;
        end
    endtask

    // One access on either port; answer read once the pulse is settled
    task automatic acc(input logic c, input logic w, input logic [7:0] a, input logic [1:0] b,
                       input logic [15:0] d, output logic [15:0] q);
        @(posedge clk_sys);
        cfgSel <= c;
        memSel <= ~c;
        {cfgWr, memWr} <= {w, w};
        {cfgAddr, memAddr} <= {a, a};
        {cfgBe, memBe} <= {b, b};
        {cfgWdata, memWdata} <= {d, d};
        @(posedge clk_sys);
        {cfgSel, memSel} <= 2'h0;
        @(negedge clk_sys);
        q = c ? cfgRdata : memRdata;
        if (!w) chk("rdValid", 16'h0001, {15'h0, c ? cfgRdValid : memRdValid});
    endtask

    task automatic wr(input logic c, input logic [7:0] a, input logic [1:0] b, input logic [15:0] d);
        logic [15:0] q;
        acc(c, 1'b1, a, b, d, q);
    endtask

    task automatic rd(input logic c, input logic [7:0] a, input logic [15:0] e);
        logic [15:0] q;
        acc(c, 1'b0, a, 2'h3, 16'h0000, q);
        chk($sformatf("reg %h", a), e, q);
    endtask

    // Bounded wait for the sequencer to reach a state
    task automatic waitFa(input logic v);
        int i;
        i = 0;
        while (frameActive !== v && i < 400) begin
            @(negedge clk_sys);
            i++;
        end
        chk("frameActive", {15'h0, v}, {15'h0, frameActive});
    endtask

    task automatic fullFrame();
        waitFa(1'b0);
        waitFa(1'b1);
        waitFa(1'b0);
    endtask

    // Length of the driven-low start and the line state in recovery
    task automatic startCheck(input logic [3:0] n, input logic fl);
        int cnt;
        cnt = 0;
        waitFa(1'b0);
        waitFa(1'b1);
        while (sirqOe === 1'b1 && sirqOut === 1'b0 && cnt < 20) begin
            cnt++;
            @(negedge clk_sys);
        end
        chk("start clocks", {12'h000, n}, 16'(cnt));
        chk("recovery oe", {15'h0, ~fl}, {15'h0, sirqOe});
        chk("recovery out", 16'h0001, {15'h0, sirqOut});
    endtask

    task automatic final_report();
        $display("Comparisons %0d, mismatches %0d", n_compared, error_cnt);
        if (error_cnt == 0 && n_compared > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask

    initial begin
        repeat (8) @(posedge clk_sys);
        rst_n <= 1'b1;
        for (int i = 0; i < 6; i++) rd(i > 2, ofs[i], 16'h0000);
        rd(1'b0, 8'h50, 16'h0000);
        wr(1'b0, MEM_MODE_OFS, 2'h3, 16'h00F1);
        rd(1'b1, CFG_MODE_OFS, 16'h0001);
        // Every width code, float toggled alongside
        for (int w = 0; w < 4; w++) begin
            wr(1'b1, CFG_MODE_OFS, 2'h1, {12'h000, w[1:0], 1'b0, w[0]});
            startCheck((w == 1) ? 4'h6 : ((w == 2) ? 4'h8 : 4'h4), w[0]);
        end
        wr(1'b1, CFG_TRIG_OFS, 2'h1, 16'hFFFF);
        rd(1'b0, MEM_TRIG_OFS, 16'h00FF);
        @(posedge clk_sys) mask <= 16'hA005;
        fullFrame();
        fullFrame();
        chk("slotAsserted", 16'hA005, slotAsserted);
        rd(1'b0, MEM_PEND_OFS, 16'h0005);
        // Clear with no new assertion, then re-assert one slot
        @(posedge clk_sys) mask <= 16'h0000;
        fullFrame();
        wr(1'b1, CFG_PEND_OFS, 2'h3, 16'h0001);
        fullFrame();
        rd(1'b0, MEM_PEND_OFS, 16'h0004);
        @(posedge clk_sys) mask <= 16'h0001;
        fullFrame();
        fullFrame();
        rd(1'b1, CFG_PEND_OFS, 16'h0005);
        for (int k = 0; k < 2; k++) begin
            wr(k == 1, k ? CFG_TRIG_OFS : MEM_TRIG_OFS, 2'h3, 16'h1234);
            rd(k == 0, k ? MEM_TRIG_OFS : CFG_TRIG_OFS, 16'h1234);
            @(posedge clk_sys) {globalReset, linkReset} <= 2'h1 << k;
            @(posedge clk_sys) {globalReset, linkReset} <= 2'h0;
            rd(k == 0, k ? MEM_TRIG_OFS : CFG_TRIG_OFS, 16'h0000);
        end
        // Quiet mode waits for a peripheral pull
        wr(1'b0, MEM_MODE_OFS, 2'h1, 16'h0002);
        waitFa(1'b0);
        repeat (200) @(negedge clk_sys);
        chk("quiet idle", 16'h0000, {15'h0, frameActive});
        @(posedge clk_sys) wake <= 1'b1;
        @(posedge clk_sys) wake <= 1'b0;
        waitFa(1'b1);
        final_report();
    end

    // Hang guard, far beyond the few dozen frames above
    initial begin
        #100000;
        error_cnt++;
        final_report();
    end
endmodule
